// ### rtl/ocmp_params.svh
// register map, field positions and reset values for the output compare channel
`ifndef OCMP_PARAMS_SVH
`define OCMP_PARAMS_SVH

`define OFS_CTRL 4'h0
`define OFS_PRI 4'h1
`define OFS_SEC 4'h2
`define OFS_IRQ_STAT 4'h3
`define OFS_IRQ_MASK 4'h4
`define OFS_PERIOD 4'h5

`define BIT_MODE_LO 0
`define BIT_TSEL 3
`define BIT_FAULT 4
`define BIT_IDLE_STOP 13

`define IRQ_MATCH 0
`define IRQ_FAULT 1
`define IRQ_W 2

`define CTRL_RESET 16'h0000
`define PERIOD_RESET 16'hffff

`endif

// ### rtl/ocmp_pkg.sv
// types shared by the output compare channel
package ocmp_pkg;
   typedef enum logic [2:0] {
      M_OFF = 3'b000,
      M_RISE = 3'b001,
      M_FALL = 3'b010,
      M_TOGGLE = 3'b011,
      M_SINGLE = 3'b100,
      M_CONT = 3'b101,
      M_PWM = 3'b110,
      M_PWM_FLT = 3'b111
   } compare_mode_t;
endpackage

// ### rtl/output_compare_channel.sv
// output compare channel with avalon-mm register slave
// -----------------------------------------------------------------
// Operation
// R1: timer select bit 3 picks time base b when set, else time base a
// R2: count compared against one or two compare registers depending on mode
// R3: pin level changes when selected count equals relevant compare value
// R4: mode 000 disables channel, pin to port logic, no interrupt
// R5: mode 001 starts pin low, match forces high, interrupt on rise
// R6: mode 010 starts pin high, match forces low, interrupt on fall
// R7: mode 011 keeps level on entry, toggles per match, interrupts both edges
// R8: mode 100 starts low, one single pulse, interrupt on its fall
// R9: mode 101 starts low, repeating pulses, interrupt on each fall
// R10: mode 110 pulse-width generator, fault ignored, no interrupt
// R11: mode 111 pulse-width with fault watched, interrupt on fault falling edge
// R12: pulse-width entry starts pin low if primary is zero, else high
// R13: fault status bit 4 set by fault in mode 111, cleared by hardware
// R14: idle-stop bit 13 halts channel during processor idle
// R15: software stops timer before rewriting control registers
// R16: only channels 0 and 1 raise a dma request
// R17: pulse modes set pin on primary match, clear on secondary match
// R18: pulse-width sets pin at period start, clears on duty match
// R19: fault low forces pin inactive until mode rewritten
// -----------------------------------------------------------------
`timescale 1ns/1ps
`include "ocmp_params.svh"

module output_compare_channel
   import ocmp_pkg::*;
#(
   parameter int CHANNEL = 0,
   parameter int W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // avalon-mm slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // time bases and system
   input wire logic [W-1:0] time_base_a,
   input wire logic [W-1:0] time_base_b,
   input wire logic cpu_idle,
   input wire logic fault_input_pin,
   // outputs
   output logic compare_output_pin,
   output logic pin_owned,
   output logic irq,
   output logic dma_req
);

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [W-1:0] primary_compare_reg;
   logic [W-1:0] secondary_compare_reg;
   logic [W-1:0] period_q;
   logic [`IRQ_W-1:0] stat_q;
   logic [`IRQ_W-1:0] mask_q;
   logic fault_q;
   logic pin_q;
   logic done_q;
   logic flt_prev_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic [2:0] prev_mode_q;
   logic [W-1:0] prev_cnt_q;

   compare_mode_t mode;
   logic [W-1:0] cnt;
   logic run;
   logic hit_pri;
   logic hit_sec;
   logic new_cnt;
   logic entered;
   logic pin_d;
   logic ev_match;
   logic ev_fault;
   logic bus_wr;
   logic lo_en;
   logic wr_ok;
   logic entry_level;
   logic match_level;
   logic period_start;
   logic fault_hold;
   logic [`IRQ_W-1:0] stat_ev;

   assign mode = compare_mode_t'(ctrl_q[`BIT_MODE_LO +: 3]);
   assign cnt = ctrl_q[`BIT_TSEL] ? time_base_b : time_base_a; // [R1]
   // idle halts only when the stop bit asks for it
   assign run = clk_en && !(ctrl_q[`BIT_IDLE_STOP] && cpu_idle); // [R14]
   // match only once per count value, since the timer may dwell on it
   assign new_cnt = cnt != prev_cnt_q;
   assign hit_pri = new_cnt && (cnt == primary_compare_reg); // [R2] [R3]
   assign hit_sec = new_cnt && (cnt == secondary_compare_reg); // [R2]
   assign entered = ctrl_q[2:0] != prev_mode_q;
   // a write lands on the edge that also shows waitrequest low
   assign bus_wr = write && ack_q;
   assign lo_en = byteenable[0] || byteenable[1];
   assign wr_ok = clk_en && bus_wr && lo_en;

   // -----------------------------------------------------------------
   // pin behaviour
   // -----------------------------------------------------------------
   // level forced on mode entry, before any match is looked at
   always_comb begin
      entry_level = pin_q;
      case (mode)
         M_OFF: begin
            entry_level = 1'b0; // [R4]
         end
         M_RISE: begin
            entry_level = 1'b0; // [R5]
         end
         M_FALL: begin
            entry_level = 1'b1; // [R6]
         end
         M_TOGGLE: begin
            entry_level = pin_q; // [R7]
         end
         M_SINGLE, M_CONT: begin
            entry_level = 1'b0; // [R8] [R9]
         end
         M_PWM, M_PWM_FLT: begin
            entry_level = primary_compare_reg != '0; // [R12]
         end
         default: begin
            entry_level = pin_q;
         end
      endcase
   end

   assign period_start = new_cnt && (cnt == '0); // [R18]
   // fault keeps the pin down even after the fault input recovers
   assign fault_hold = (mode == M_PWM_FLT) && (fault_q || !fault_input_pin); // [R19]

   // level after this cycle's matches while the mode stands
   always_comb begin
      match_level = pin_q;
      case (mode)
         M_RISE: begin
            if (hit_pri) begin
               match_level = 1'b1; // [R5]
            end
         end
         M_FALL: begin
            if (hit_pri) begin
               match_level = 1'b0; // [R6]
            end
         end
         M_TOGGLE: begin
            if (hit_pri) begin
               match_level = !pin_q; // [R7]
            end
         end
         M_SINGLE: begin
            if (hit_pri && !done_q) begin
               match_level = 1'b1; // [R17]
            end
            if (hit_sec && pin_q) begin
               match_level = 1'b0; // [R8] [R17]
            end
         end
         M_CONT: begin
            if (hit_pri) begin
               match_level = 1'b1; // [R17]
            end
            if (hit_sec) begin
               match_level = 1'b0; // [R9] [R17]
            end
         end
         M_PWM, M_PWM_FLT: begin
            // period start wins over a duty match; with a duty of zero it sets the pin low
            if (period_start) begin
               match_level = primary_compare_reg != '0; // [R18]
            end else if (hit_pri) begin
               match_level = 1'b0; // [R18]
            end
            if (fault_hold) begin
               match_level = 1'b0; // [R19]
            end
         end
         default: begin
            match_level = pin_q;
         end
      endcase
   end

   assign pin_d = entered ? entry_level : match_level;

   // -----------------------------------------------------------------
   // events
   // -----------------------------------------------------------------
   always_comb begin
      ev_match = 1'b0;
      case (mode)
         M_RISE: begin
            ev_match = !pin_q && pin_d; // [R5]
         end
         M_FALL: begin
            ev_match = pin_q && !pin_d; // [R6]
         end
         M_TOGGLE: begin
            ev_match = pin_q != pin_d; // [R7]
         end
         M_SINGLE, M_CONT: begin
            ev_match = pin_q && !pin_d; // [R8] [R9]
         end
         default: begin
            ev_match = 1'b0; // [R4] [R10]
         end
      endcase
      // entry levels are set up, not matched, so they raise nothing
      if (entered) begin
         ev_match = 1'b0;
      end
   end

   assign ev_fault = mode == M_PWM_FLT && flt_prev_q && !fault_input_pin; // [R11]
   assign stat_ev[`IRQ_MATCH] = ev_match;
   assign stat_ev[`IRQ_FAULT] = ev_fault;

   // -----------------------------------------------------------------
   // channel state
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_q <= 1'b0;
      end else if (run) begin
         pin_q <= pin_d;
      end
   end

   // history for mode entry, count change and fault edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_mode_q <= 3'h0;
         prev_cnt_q <= '0;
         // idle level of the fault pin, so reset shows no false edge
         flt_prev_q <= 1'b1;
      end else if (run) begin
         prev_mode_q <= ctrl_q[2:0];
         prev_cnt_q <= cnt;
         flt_prev_q <= fault_input_pin;
      end
   end

   // single pulse spent; only a new mode rearms it
   always_ff @(posedge clk) begin
      if (rst) begin
         done_q <= 1'b0;
      end else if (run) begin
         if (entered) begin
            done_q <= 1'b0;
         end else if (mode == M_SINGLE && pin_q && !pin_d) begin
            done_q <= 1'b1; // [R8]
         end
      end
   end

   // fault flag: hardware sets, cleared by hardware when the mode changes or is not 111
   always_ff @(posedge clk) begin
      if (rst) begin
         fault_q <= 1'b0;
      end else if (run) begin
         if (ev_fault) begin
            fault_q <= 1'b1; // [R13]
         end else if (mode != M_PWM_FLT || entered) begin
            fault_q <= 1'b0; // [R13] [R19]
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         compare_output_pin <= 1'b0;
         pin_owned <= 1'b0;
         dma_req <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         compare_output_pin <= pin_q;
         pin_owned <= mode != M_OFF; // [R4]
         dma_req <= (CHANNEL < 2) && run && (ev_match || ev_fault); // [R16]
         irq <= |(stat_q & mask_q);
      end
   end

   // -----------------------------------------------------------------
   // register slave: one wait cycle per access
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         waitrequest <= 1'b1;
      end else if (clk_en) begin
         ack_q <= (read || write) && !ack_q;
         waitrequest <= !((read || write) && !ack_q);
      end
   end

   // software rewrites assume the timer is stopped beforehand [R15]
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_ok && address == `OFS_CTRL) begin
         // only the implemented bits take writes; the fault bit is read only
         ctrl_q[`BIT_MODE_LO +: 3] <= writedata[`BIT_MODE_LO +: 3];
         ctrl_q[`BIT_TSEL] <= writedata[`BIT_TSEL];
         ctrl_q[`BIT_IDLE_STOP] <= writedata[`BIT_IDLE_STOP];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         primary_compare_reg <= '0;
      end else if (wr_ok && address == `OFS_PRI) begin
         primary_compare_reg <= writedata[W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         secondary_compare_reg <= '0;
      end else if (wr_ok && address == `OFS_SEC) begin
         secondary_compare_reg <= writedata[W-1:0];
      end
   end

   // period is kept for software only; the count wrap marks period start
   always_ff @(posedge clk) begin
      if (rst) begin
         period_q <= W'(`PERIOD_RESET);
      end else if (wr_ok && address == `OFS_PERIOD) begin
         period_q <= writedata[W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= '0;
      end else if (wr_ok && address == `OFS_IRQ_MASK) begin
         mask_q <= writedata[`IRQ_W-1:0];
      end
   end

   // sticky status, set wins over write-one-to-clear
   for (genvar i = 0; i < `IRQ_W; i++) begin : g_stat
      always_ff @(posedge clk) begin
         if (rst) begin
            stat_q[i] <= 1'b0;
         end else if (clk_en) begin
            if (run && stat_ev[i]) begin
               stat_q[i] <= 1'b1; // [R5] [R11]
            end else if (wr_ok && address == `OFS_IRQ_STAT && writedata[i]) begin
               stat_q[i] <= 1'b0;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // read data
   // -----------------------------------------------------------------
   // loaded when the read is first seen, stands until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (clk_en && read && !ack_q) begin
         case (address)
            `OFS_CTRL: begin
               rdata_q <= {16'h0000, ctrl_q[15:5], fault_q, ctrl_q[3:0]}; // [R13]
            end
            `OFS_PRI: begin
               rdata_q <= 32'(primary_compare_reg);
            end
            `OFS_SEC: begin
               rdata_q <= 32'(secondary_compare_reg);
            end
            `OFS_PERIOD: begin
               rdata_q <= 32'(period_q);
            end
            `OFS_IRQ_STAT: begin
               rdata_q <= 32'(stat_q);
            end
            `OFS_IRQ_MASK: begin
               rdata_q <= 32'(mask_q);
            end
            default: begin
               rdata_q <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign readdata = rdata_q;

endmodule // output_compare_channel

// ### tb/ocmp_asserts.sv
// port checker for the output compare channel
`timescale 1ns/1ps
module ocmp_asserts #(
   parameter int W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // time bases and pins
   input wire logic [W-1:0] time_base_a,
   input wire logic [W-1:0] time_base_b,
   input wire logic fault_input_pin,
   input wire logic compare_output_pin,
   input wire logic pin_owned,
   input wire logic irq,
   input wire logic dma_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   rst_out_a: assert property (disable iff (1'b0) rst |=> waitrequest && !irq && !dma_req
      && !compare_output_pin && !pin_owned) else $error("outputs not cleared by reset");
   ack_time_a: assert property ((read || write) && !$past(read || write) |=> !waitrequest)
      else $error("bus answer not one cycle after request");
   ack_pulse_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   rd_hold_a: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
   hi_zero_a: assert property (readdata[31:16] == 16'h0000)
      else $error("upper read data bits not zero");
   quiet_pin_a: assert property ((!write && $stable(time_base_a) && $stable(time_base_b)
      && $stable(fault_input_pin))[*4] |=> $stable(compare_output_pin))
      else $error("pin moved with no count change or write");
   owned_wr_a: assert property ($changed(pin_owned) |-> $past(write) || $past(write, 2))
      else $error("pin ownership changed without a write");
   dma_pulse_a: assert property (dma_req |=> !dma_req)
      else $error("dma request longer than one cycle");
endmodule // ocmp_asserts

bind output_compare_channel ocmp_asserts #(.W(W)) u_ocmp_asserts (.clk(clk), .rst(rst),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .time_base_a(time_base_a), .time_base_b(time_base_b), .fault_input_pin(fault_input_pin),
   .compare_output_pin(compare_output_pin), .pin_owned(pin_owned), .irq(irq),
   .dma_req(dma_req));

// ### tb/testbench.sv
// self-checking bench for the output compare channel
`timescale 1ns/1ps
`include "ocmp_params.svh"
module testbench;
   logic clk = 1'h0, rst = 1'h1, clk_en = 1'h1, read = 1'h0, write = 1'h0, cpu_idle = 1'h0;
   logic fault_input_pin = 1'h1, compare_output_pin, pin_owned, irq, dma_req, waitrequest;
   logic [3:0] address = 4'h0, byteenable = 4'h3;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [15:0] time_base_a = 16'h0, time_base_b = 16'h0;
   int error_cnt = 0, num_checks = 0, dma_cnt = 0;
   typedef struct packed {logic [2:0] m; logic b, z, i0, i1, i2, i3, s1, s2;} row_t;
   // mode, timer b, primary zero, pin at entry and after three steps, irq, status
   row_t rows [7] = '{11'b001_0_0_0111_11, 11'b010_1_0_1000_11, 11'b011_0_0_0110_11,
      11'b100_1_0_0100_01, 11'b101_0_0_0101_01, 11'b110_1_0_1000_00, 11'b111_0_1_0000_00};

   output_compare_channel #(.CHANNEL(0), .W(16)) u_output_compare_channel (.*);

   initial begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (dma_req === 1'h1) dma_cnt++;
   end

   // ------
   // shared tasks
   // ------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
      int n = 0;
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'h0 && n < 40);
      rd = readdata;
      read <= 1'h0;
      write <= 1'h0;
      if (n == 40) begin
         error_cnt++;
         finish_test();
      end
   endtask

   // the unselected base sits away from both compare values
   task automatic cnt(input logic b, input logic [15:0] v);
      @(posedge clk);
      time_base_a <= b ? 16'h0250 : v;
      time_base_b <= b ? v : 16'h0250;
      repeat (4) @(posedge clk);
   endtask

   task automatic flt(input logic v);
      @(posedge clk);
      fault_input_pin <= v;
      repeat (4) @(posedge clk);
   endtask

   // ------
   // main sequence
   // ------
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      bus(1'h0, `OFS_PERIOD, 16'h0);
      chk(rd, 32'hffff);
      bus(1'h0, `OFS_CTRL, 16'h0);
      chk(rd, 32'h0);
      bus(1'h1, `OFS_IRQ_MASK, 16'h0003);
      foreach (rows[k]) begin
         bus(1'h1, `OFS_PRI, rows[k].z ? 16'h0000 : 16'h0200);
         bus(1'h1, `OFS_SEC, 16'h0300);
         bus(1'h1, `OFS_CTRL, {12'h000, rows[k].b, rows[k].m});
         cnt(rows[k].b, 16'h0100);
         chk(compare_output_pin, rows[k].i0);
         chk(pin_owned, 1'h1);
         bus(1'h1, `OFS_IRQ_STAT, 16'h0003);
         cnt(rows[k].b, 16'h0200);
         chk(compare_output_pin, rows[k].i1);
         chk(irq, rows[k].s1);
         cnt(rows[k].b, 16'h0300);
         chk(compare_output_pin, rows[k].i2);
         bus(1'h0, `OFS_IRQ_STAT, 16'h0);
         chk(rd, {31'h0, rows[k].s2});
         cnt(rows[k].b, 16'h0200);
         chk(compare_output_pin, rows[k].i3);
      end
      bus(1'h1, `OFS_PRI, 16'h0200);
      bus(1'h1, `OFS_CTRL, 16'h0006);
      bus(1'h1, `OFS_IRQ_STAT, 16'h0003);
      flt(1'h0);
      chk(compare_output_pin, 1'h1);
      chk(irq, 1'h0);
      flt(1'h1);
      bus(1'h1, `OFS_CTRL, 16'h0007);
      flt(1'h0);
      chk(compare_output_pin, 1'h0);
      chk(irq, 1'h1);
      bus(1'h0, `OFS_CTRL, 16'h0);
      chk(rd, 32'h0017);
      flt(1'h1);
      chk(compare_output_pin, 1'h0);
      bus(1'h1, `OFS_IRQ_MASK, 16'h0000);
      repeat (4) @(posedge clk);
      chk(irq, 1'h0);
      bus(1'h1, `OFS_IRQ_MASK, 16'h0003);
      bus(1'h1, `OFS_IRQ_STAT, 16'h0003);
      bus(1'h0, `OFS_IRQ_STAT, 16'h0);
      chk(rd, 32'h0);
      chk(irq, 1'h0);
      bus(1'h1, `OFS_CTRL, 16'h0006);
      bus(1'h0, `OFS_CTRL, 16'h0);
      chk(rd, 32'h0006);
      // idle halt, then the same idle level with halting off
      bus(1'h1, `OFS_CTRL, 16'h2001);
      // let the mode entry happen before the halt starts
      repeat (2) @(posedge clk);
      cpu_idle <= 1'h1;
      cnt(1'h0, 16'h0100);
      cnt(1'h0, 16'h0200);
      chk(compare_output_pin, 1'h0);
      bus(1'h1, `OFS_CTRL, 16'h0001);
      cnt(1'h0, 16'h0100);
      cnt(1'h0, 16'h0200);
      chk(compare_output_pin, 1'h1);
      bus(1'h1, `OFS_CTRL, 16'h0000);
      bus(1'h1, `OFS_IRQ_STAT, 16'h0003);
      cnt(1'h0, 16'h0100);
      cnt(1'h0, 16'h0200);
      chk(pin_owned, 1'h0);
      chk(irq, 1'h0);
      bus(1'h1, 4'h6, 16'h1234);
      bus(1'h0, 4'h6, 16'h0);
      chk(rd, 32'h0);
      chk(dma_cnt != 0, 1'h1);
      finish_test();
   end
endmodule // testbench
